// >>> pkg/srh_pkg.sv
package srh_pkg;
    // ==========================================
    // suspend handshake constants
    // ==========================================
    localparam logic       SUSPEND_REQUEST_N_EN_RST     = 1'b0;
    localparam logic       STOP_ALL_RST    = 1'b0;
    localparam logic [3:0] DRAIN_CNT_RST   = 4'h0;
    localparam int         DRAIN_MAX_CYC   = 15;

    typedef enum logic [3:0] {
        SRH_RUN   = 4'b0001,
        SRH_DRAIN = 4'b0010,
        SRH_SUSPEND_REQUEST_N  = 4'b0100,
        SRH_WAKE  = 4'b1000
    } srh_state_e;
endpackage

// >>> src/srh_sync.sv
module srh_sync (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic d_i,
    output logic      q_o
);
    // ==========================================
    // two-stage synchroniser, resets high (idle)
    // ==========================================
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// >>> src/srh_top.sv
module srh_top
    import srh_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic suspend_request_n_i,
    input  wire logic suspend_pin_enable_i,
    input  wire logic stop_all_clocks_i,
    input  wire logic halt_exec_i,
    input  wire logic core_busy_i,
    input  wire logic resume_event_i,
    output logic      suspend_ack_n_o,
    output logic      suspend_ack_n_oe_o,
    output logic      core_clk_stop_o,
    output logic      all_clk_stop_o,
    output logic      ref_clk_stoppable_o
);
    // ==========================================
    // reset release and pin synchronisation
    // ==========================================
    logic rst_meta_ff;
    logic rst_n_ff;
    logic req_n_sync;

    // release is delayed two edges so no flop sees the async edge near a clock
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    srh_sync u_req_sync (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (rst_n_ff),
        .d_i       (suspend_request_n_i),
        .q_o       (req_n_sync)
    );

    // ==========================================
    // state
    // ==========================================
    typedef struct packed {
        srh_state_e st;
        logic       en;
        logic       stop_all;
        logic       by_halt;
        logic [3:0] drain;
        logic       ack;
    } srh_regs_s;

    srh_regs_s cur_ff;
    srh_regs_s nxt_cur;
    logic      req_act;

    // ==========================================
    // decode helpers
    // ==========================================
    // one place decides what counts as suspended, so core_clk_stop_o and all_clk_stop_o agree
    function automatic logic in_suspend_request_n(input srh_state_e st);
        return st == SRH_SUSPEND_REQUEST_N;
    endfunction

    // a halt suspend ends on an interrupt, a request suspend on release
    function automatic logic wake_due(input logic by_halt, input logic req_n, input logic resume, input logic en);
        return (!by_halt && req_n) || (by_halt && resume) || !en;
    endfunction

    // request only counts once the pin is enabled
    assign req_act = cur_ff.en && !req_n_sync;

    always_comb begin
        nxt_cur          = cur_ff;
        nxt_cur.en       = suspend_pin_enable_i;
        case (cur_ff.st)
            SRH_RUN: begin
                nxt_cur.ack = 1'b0;
                if (req_act || (cur_ff.en && halt_exec_i)) begin
                    nxt_cur.st       = SRH_DRAIN;
                    nxt_cur.by_halt  = !req_act;
                    nxt_cur.stop_all = stop_all_clocks_i;
                    nxt_cur.drain    = DRAIN_CNT_RST;
                end
            end
            SRH_DRAIN: begin
                // wait for instruction and bus cycles in flight to retire
                // stall count is for debug only; it saturates rather than wrap
                if (!core_busy_i) begin
                    nxt_cur.st  = SRH_SUSPEND_REQUEST_N;
                    nxt_cur.ack = 1'b1;
                end else if (cur_ff.drain != 4'(DRAIN_MAX_CYC)) begin
                    nxt_cur.drain = cur_ff.drain + 4'h1;
                end
            end
            SRH_SUSPEND_REQUEST_N: begin
                // dropping the enable also wakes, so ack clears one cycle after the pin starts floating
                if (wake_due(cur_ff.by_halt, req_n_sync, resume_event_i, cur_ff.en)) begin
                    nxt_cur.st  = SRH_WAKE;
                    nxt_cur.ack = 1'b0;
                end
            end
            SRH_WAKE: begin
                nxt_cur.st = SRH_RUN;
            end
            default: begin
                nxt_cur.st  = SRH_RUN;
                nxt_cur.ack = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cur_ff <= '{st: SRH_RUN, en: SUSPEND_REQUEST_N_EN_RST, stop_all: STOP_ALL_RST,
                        by_halt: 1'b0, drain: DRAIN_CNT_RST, ack: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ==========================================
    // outputs
    // ==========================================
    assign suspend_ack_n_o     = !cur_ff.ack;
    assign suspend_ack_n_oe_o  = cur_ff.en;
    assign core_clk_stop_o     = in_suspend_request_n(cur_ff.st);
    assign all_clk_stop_o      = in_suspend_request_n(cur_ff.st) && cur_ff.stop_all;
    // tells the board the reference clock may halt; only valid with ack shown
    assign ref_clk_stoppable_o = cur_ff.ack && cur_ff.stop_all && cur_ff.en;

    // ==========================================
    // assertions
    // ==========================================
    AST_NO_ACK_WHEN_DISABLED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        !cur_ff.en |-> !suspend_ack_n_oe_o)
        else $error("ack driven while pin disabled");
    AST_IGNORE_REQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_RUN && !cur_ff.en) |=> cur_ff.st != SRH_DRAIN)
        else $error("request taken while disabled");
    AST_DRAIN_FIRST: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_DRAIN && core_busy_i) |=> cur_ff.st == SRH_DRAIN)
        else $error("suspend before drain");
    AST_ACK_IN_SUSPEND_REQUEST_N: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_DRAIN && !core_busy_i) |=> (!suspend_ack_n_o && core_clk_stop_o))
        else $error("ack not given on suspend");
    AST_ACK_ONLY_SUSPEND_REQUEST_N: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        !suspend_ack_n_o |-> cur_ff.st == SRH_SUSPEND_REQUEST_N)
        else $error("ack outside suspend");
    AST_ALL_STOP_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        all_clk_stop_o |-> (core_clk_stop_o && cur_ff.stop_all))
        else $error("all clocks stopped in core-only mode");
    AST_REF_STOP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        ref_clk_stoppable_o |-> (!suspend_ack_n_o && all_clk_stop_o))
        else $error("reference stop allowed early");
    AST_WAKE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_SUSPEND_REQUEST_N && !cur_ff.by_halt && req_n_sync && cur_ff.en) |=> suspend_ack_n_o ##1 !core_clk_stop_o)
        else $error("no resume on release");

    // entry: nothing is taken while disabled, and ack never precedes the drain
    AST_OE_AFTER_EN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        $rose(suspend_ack_n_oe_o) |-> $past(suspend_pin_enable_i))
        else $error("ack driven before enable set");
    AST_REQ_ENTRY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_RUN && req_act) |=> (cur_ff.st == SRH_DRAIN && !cur_ff.by_halt))
        else $error("request not taken");
    AST_HALT_ENTRY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_RUN && !req_act && cur_ff.en && halt_exec_i) |=> (cur_ff.st == SRH_DRAIN && cur_ff.by_halt))
        else $error("halt not taken");
    AST_NO_EARLY_ACK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st == SRH_RUN |=> suspend_ack_n_o)
        else $error("ack before drain");
    AST_DRAIN_SAT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_DRAIN && cur_ff.drain == 4'(DRAIN_MAX_CYC)) |=> cur_ff.drain == 4'(DRAIN_MAX_CYC))
        else $error("drain count wrapped");

    // mode: latched at entry, fixed while suspended
    AST_MODE_LATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_RUN && (req_act || (cur_ff.en && halt_exec_i)))
            |=> cur_ff.stop_all == $past(stop_all_clocks_i))
        else $error("clock mode not latched");
    AST_MODE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st != SRH_RUN |=> $stable(cur_ff.stop_all))
        else $error("clock mode changed in suspend");
    AST_CORE_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (core_clk_stop_o && !cur_ff.stop_all) |-> !all_clk_stop_o)
        else $error("core-only suspend stopped everything");

    // wake: each cause leads through one wake cycle back to run
    AST_HOLD_SUSPEND_REQUEST_N: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_SUSPEND_REQUEST_N && !cur_ff.by_halt && !req_n_sync && cur_ff.en)
            |=> (cur_ff.st == SRH_SUSPEND_REQUEST_N && !suspend_ack_n_o))
        else $error("suspend left while request held");
    AST_HALT_WAKE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_SUSPEND_REQUEST_N && cur_ff.by_halt && resume_event_i) |=> (cur_ff.st == SRH_WAKE && suspend_ack_n_o))
        else $error("halt suspend not ended by interrupt");
    AST_EN_DROP_WAKE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        (cur_ff.st == SRH_SUSPEND_REQUEST_N && !cur_ff.en) |=> (cur_ff.st == SRH_WAKE && suspend_ack_n_o))
        else $error("suspend kept after enable cleared");
    AST_WAKE_TO_RUN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st == SRH_WAKE |=> (cur_ff.st == SRH_RUN && !core_clk_stop_o))
        else $error("wake did not return to run");

    COV_REQ_SUSPEND_REQUEST_N: cover property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st == SRH_SUSPEND_REQUEST_N && !cur_ff.by_halt);
    COV_HALT_SUSPEND_REQUEST_N: cover property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st == SRH_SUSPEND_REQUEST_N && cur_ff.by_halt);
    COV_ALL_STOP: cover property (@(posedge sys_clk_i) disable iff (!rst_n_ff) ref_clk_stoppable_o);
    // a long drain and a suspend cut short by the enable
    COV_EN_DROP: cover property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st == SRH_SUSPEND_REQUEST_N && !cur_ff.en);
    COV_DRAIN_WAIT: cover property (@(posedge sys_clk_i) disable iff (!rst_n_ff)
        cur_ff.st == SRH_DRAIN && cur_ff.drain == 4'(DRAIN_MAX_CYC));
endmodule

// >>> verif/srh_pm_ctrl_model.sv
module srh_pm_ctrl_model (
    input  wire logic sys_clk_i,
    input  wire logic want_suspend_i,
    input  wire logic suspend_ack_n_i,
    input  wire logic ref_clk_stoppable_i,
    output logic      suspend_request_n_o,
    output logic      ref_clk_gate_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // controller side of the handshake
    // ==========================================
    initial suspend_request_n_o = 1'b1;
    initial ref_clk_gate_o = 1'b0;
    // request stays low for as long as suspend is wanted
    always @(negedge sys_clk_i) suspend_request_n_o <= ~want_suspend_i;
    // reference clock may stop only after ack and only in stop-all mode
    always @(negedge sys_clk_i) begin
        ref_clk_gate_o <= want_suspend_i && (suspend_ack_n_i === 1'b0) && ref_clk_stoppable_i;
    end
endmodule

// >>> verif/test_suspend_request_handshake.sv
module test_suspend_request_handshake;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i = 0, resetn_i = 0, en = 0, stop_all = 0, halt = 0, busy = 0, resume = 0, want = 0;
    wire logic req_n, ack_n, oe, core_stop, all_stop, stoppable, gate, ack_pin;
    int   miscompares = 0, comparisons = 0, cycles = 0;
    // board pull-up holds the ack pin high while the device floats it
    assign ack_pin = oe ? ack_n : 1'b1;
    srh_top uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .suspend_request_n_i(req_n),
        .suspend_pin_enable_i(en), .stop_all_clocks_i(stop_all), .halt_exec_i(halt),
        .core_busy_i(busy), .resume_event_i(resume), .suspend_ack_n_o(ack_n),
        .suspend_ack_n_oe_o(oe), .core_clk_stop_o(core_stop), .all_clk_stop_o(all_stop),
        .ref_clk_stoppable_o(stoppable));
    srh_pm_ctrl_model pm (.sys_clk_i(sys_clk_i), .want_suspend_i(want), .suspend_ack_n_i(ack_pin),
        .ref_clk_stoppable_i(stoppable), .suspend_request_n_o(req_n), .ref_clk_gate_o(gate));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    // ==========================================
    // helpers
    // ==========================================
    task end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // the whole run needs well under two hundred cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            end_of_test();
        end
    end
    task chk(input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task wait_ack(input logic lvl);
        int k;
        k = 0;
        while (ack_n !== lvl && k < 20) begin
            tick(1);
            k++;
        end
    endtask
    // ==========================================
    // scenarios
    // ==========================================
    task t_disabled;
        chk(oe, 1'b0);
        want = 1;
        halt = 1;
        tick(10);
        chk(oe, 1'b0);
        chk(ack_pin, 1'b1);
        chk(ack_n, 1'b1);
        chk(core_stop, 1'b0);
        want = 0;
        halt = 0;
        tick(4);
        $display("test disabled done");
    endtask
    task t_request(input logic mode);
        en = 1;
        stop_all = mode;
        busy = 1;
        tick(2);
        chk(oe, 1'b1);
        want = 1;
        tick(20);
        chk(ack_n, 1'b1);
        chk(core_stop, 1'b0);
        busy = 0;
        wait_ack(0);
        tick(2);
        chk(ack_n, 1'b0);
        chk(core_stop, 1'b1);
        chk(all_stop, mode);
        chk(stoppable, mode);
        chk(gate, mode);
        want = 0;
        wait_ack(1);
        tick(2);
        chk(ack_n, 1'b1);
        chk(core_stop, 1'b0);
        chk(all_stop, 1'b0);
        chk(gate, 1'b0);
        $display("test request mode %0d done", mode);
    endtask
    task t_en_drop;
        en = 1;
        stop_all = 0;
        tick(2);
        want = 1;
        wait_ack(0);
        tick(1);
        en = 0;
        tick(3);
        chk(ack_n, 1'b1);
        chk(oe, 1'b0);
        chk(ack_pin, 1'b1);
        chk(core_stop, 1'b0);
        want = 0;
        tick(4);
        $display("test enable drop done");
    endtask
    task t_reset_in_suspend_request_n;
        en = 1;
        tick(2);
        want = 1;
        wait_ack(0);
        resetn_i = 0;
        en = 0;
        tick(2);
        chk(oe, 1'b0);
        chk(ack_n, 1'b1);
        chk(stoppable, 1'b0);
        resetn_i = 1;
        tick(6);
        chk(core_stop, 1'b0);
        chk(ack_pin, 1'b1);
        want = 0;
        tick(4);
        $display("test reset in suspend done");
    endtask
    task t_halt;
        en = 1;
        stop_all = 0;
        tick(2);
        halt = 1;
        tick(1);
        halt = 0;
        wait_ack(0);
        tick(5);
        chk(ack_n, 1'b0);
        chk(core_stop, 1'b1);
        resume = 1;
        tick(1);
        resume = 0;
        wait_ack(1);
        tick(2);
        chk(ack_n, 1'b1);
        chk(core_stop, 1'b0);
        $display("test halt done");
    endtask
    initial begin
        tick(10);
        resetn_i = 1;
        tick(3);
        t_disabled();
        t_request(1'b0);
        t_request(1'b1);
        t_en_drop();
        t_reset_in_suspend_request_n();
        t_halt();
        end_of_test();
    end
endmodule
